// file: design/pcm_defines.svh
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

// management register addresses
`define PCM_ADDR_CONTROL 5'h00
`define PCM_ADDR_STATUS 5'h01
`define PCM_ADDR_IDENT_HIGH 5'h02
`define PCM_ADDR_IDENT_LOW 5'h03
`define PCM_ADDR_EXT_CONTROL 5'h0d
`define PCM_ADDR_EXT_DATA 5'h0e

// control register fields
`define PCM_CTL_SOFT_RESET 15
`define PCM_CTL_PCS_LOOP 14
`define PCM_CTL_SPEED_LOW 13
`define PCM_CTL_AUTONEG 12
`define PCM_CTL_POWERDOWN 11
`define PCM_CTL_MII_DETACH 10
`define PCM_CTL_DUPLEX 8
`define PCM_CTL_COLL_TEST 7
`define PCM_CTL_SPEED_HIGH 6
`define PCM_CTL_ONE_WAY 5

// status register fields
`define PCM_STS_FD10_ABLE 12
`define PCM_STS_AN_COMPLETE 5
`define PCM_STS_AN_ABLE 3
`define PCM_STS_LINK 2
`define PCM_STS_EXT_CAPABLE 0

// extended access control function field
`define PCM_EXT_FUNC_HI 15
`define PCM_EXT_FUNC_LO 14

// reset values
`define PCM_CONTROL_RESET 16'h1100
`define PCM_STATUS_RESET 16'h1009
`define PCM_EXT_RESET 16'h0000

// length of the software reset cycle in clocks
`define PCM_SOFT_RESET_CYCLES 16

`endif

// file: design/pcm_pkg.sv
package pcm_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pcm_mgmt_req_t;

  typedef struct packed {
    logic soft_reset;
    logic pcs_local_loop;
    logic soft_powerdown;
    logic mii_detach;
    logic autoneg_on;
  } pcm_phy_ctrl_t;

  typedef enum logic {
    PCM_IDLE,
    PCM_SOFT_RESET
  } pcm_state_t;

endpackage

// file: design/pcm_regs.sv
`include "pcm_defines.svh"

// Notes on behaviour
// - control bit 15 write of one starts a self-clearing soft reset cycle
// - control bit 14 read/write, engages pcs local loopback, resets to zero
// - control bit 12 read-only autoneg indication, one unless forced link mode
// - control bit 11 powers down the phy; registers stay accessible
// - power-down reset value follows strap pin sampled after reset
// - control bit 10 read/write, detaches phy from mii, resets to zero
// - control bit 8 always reads one, writes ignored
// - control bit 7 always reads zero, writes ignored
// - speed bits 6 and 13 always read zero, writes ignored
// - control bit 5 always reads zero, writes ignored
// - decode control, status, two ident words, ext control and ext data
// - ext control bits 15:14 select the kind of ext data access
// - status link bit latches low until status is read
module pcm_regs #(
  parameter int unsigned SOFT_RESET_CYCLES = `PCM_SOFT_RESET_CYCLES,
  // identifier values are arbitrary
  parameter logic [15:0] IDENT_HIGH = 16'h1234,
  parameter logic [15:0] IDENT_LOW = 16'h5671
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // management access
  input wire pcm_pkg::pcm_mgmt_req_t mgmt_req_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // phy status inputs
  input wire logic powerdown_strap_pin_i,
  input wire logic link_up_i,
  input wire logic an_complete_i,
  input wire logic forced_link_mode_enable_i,
  // phy control outputs
  output pcm_pkg::pcm_phy_ctrl_t phy_ctrl_o,
  output logic [1:0] ext_access_function_select_o,
  output logic [15:0] ext_data_o,
  output logic ext_data_write_o
);

  localparam int unsigned CW = $clog2(SOFT_RESET_CYCLES + 1);

  pcm_pkg::pcm_state_t state;
  logic [CW-1:0] reset_count;
  logic pcs_local_loop;
  logic soft_powerdown;
  logic mii_detach;
  logic strap_pending;
  logic latched_link_state;
  logic [15:0] ext_reg_access_control;
  logic [15:0] ext_reg_access_data;
  logic [15:0] ctrl_value;
  logic [15:0] status_value;
  logic [15:0] next_rdata;
  logic wr;
  logic rd;
  logic wr_ok;
  logic soft_done;

  assign wr = mgmt_req_i.valid & mgmt_req_i.write;
  assign rd = mgmt_req_i.valid & ~mgmt_req_i.write;
  assign wr_ok = wr & (state == pcm_pkg::PCM_IDLE);
  assign soft_done = (state == pcm_pkg::PCM_SOFT_RESET) && (reset_count == '0);

  // soft reset sequencer
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= pcm_pkg::PCM_IDLE;
      reset_count <= '0;
    end else begin
      unique case (state)
        pcm_pkg::PCM_IDLE: begin
          if (wr_ok && mgmt_req_i.addr == `PCM_ADDR_CONTROL
              && mgmt_req_i.wdata[`PCM_CTL_SOFT_RESET]) begin
            state <= pcm_pkg::PCM_SOFT_RESET;
            reset_count <= CW'(SOFT_RESET_CYCLES - 1);
          end
        end
        pcm_pkg::PCM_SOFT_RESET: begin
          if (reset_count == '0) begin
            state <= pcm_pkg::PCM_IDLE;
          end else begin
            reset_count <= reset_count - 1'b1;
          end
        end
      endcase
    end
  end

  // writable control fields
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pcs_local_loop <= 1'b0;
      mii_detach <= 1'b0;
    end else if (soft_done) begin
      pcs_local_loop <= 1'b0;
      mii_detach <= 1'b0;
    end else if (wr_ok && mgmt_req_i.addr == `PCM_ADDR_CONTROL) begin
      pcs_local_loop <= mgmt_req_i.wdata[`PCM_CTL_PCS_LOOP];
      mii_detach <= mgmt_req_i.wdata[`PCM_CTL_MII_DETACH];
    end
  end

  // power-down, loaded from the strap one clock after reset release
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_pending <= 1'b1;
      soft_powerdown <= 1'b1;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      soft_powerdown <= powerdown_strap_pin_i;
    end else if (soft_done) begin
      strap_pending <= 1'b1;
    end else if (wr_ok && mgmt_req_i.addr == `PCM_ADDR_CONTROL) begin
      soft_powerdown <= mgmt_req_i.wdata[`PCM_CTL_POWERDOWN];
    end
  end

  // extended access pair
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_reg_access_control <= `PCM_EXT_RESET;
      ext_reg_access_data <= `PCM_EXT_RESET;
    end else if (soft_done) begin
      ext_reg_access_control <= `PCM_EXT_RESET;
      ext_reg_access_data <= `PCM_EXT_RESET;
    end else if (wr_ok) begin
      if (mgmt_req_i.addr == `PCM_ADDR_EXT_CONTROL) begin
        ext_reg_access_control <= mgmt_req_i.wdata;
      end
      if (mgmt_req_i.addr == `PCM_ADDR_EXT_DATA) begin
        ext_reg_access_data <= mgmt_req_i.wdata;
      end
    end
  end

  // latch-low link status; a failing link wins over the read clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latched_link_state <= 1'b0;
    end else if (!link_up_i) begin
      latched_link_state <= 1'b0;
    end else if (rd && mgmt_req_i.addr == `PCM_ADDR_STATUS) begin
      latched_link_state <= 1'b1;
    end
  end

  // read values
  always_comb begin
    ctrl_value = 16'h0000;
    ctrl_value[`PCM_CTL_SOFT_RESET] = (state == pcm_pkg::PCM_SOFT_RESET);
    ctrl_value[`PCM_CTL_PCS_LOOP] = pcs_local_loop;
    ctrl_value[`PCM_CTL_AUTONEG] = ~forced_link_mode_enable_i;
    ctrl_value[`PCM_CTL_POWERDOWN] = soft_powerdown;
    ctrl_value[`PCM_CTL_MII_DETACH] = mii_detach;
    ctrl_value[`PCM_CTL_DUPLEX] = 1'b1;
    status_value = 16'h0000;
    status_value[`PCM_STS_FD10_ABLE] = 1'b1;
    status_value[`PCM_STS_AN_COMPLETE] = an_complete_i;
    status_value[`PCM_STS_AN_ABLE] = 1'b1;
    status_value[`PCM_STS_LINK] = latched_link_state;
    status_value[`PCM_STS_EXT_CAPABLE] = 1'b1;
    unique case (mgmt_req_i.addr)
      `PCM_ADDR_CONTROL: next_rdata = ctrl_value;
      `PCM_ADDR_STATUS: next_rdata = status_value;
      `PCM_ADDR_IDENT_HIGH: next_rdata = IDENT_HIGH;
      `PCM_ADDR_IDENT_LOW: next_rdata = IDENT_LOW;
      `PCM_ADDR_EXT_CONTROL: next_rdata = ext_reg_access_control;
      `PCM_ADDR_EXT_DATA: next_rdata = ext_reg_access_data;
      default: next_rdata = 16'h0000;
    endcase
  end

  // read answer, one clock after the request
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_rdata_o <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rvalid_o <= rd;
      if (rd) begin
        mgmt_rdata_o <= next_rdata;
      end
    end
  end

  // ext data write strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_data_write_o <= 1'b0;
    end else begin
      ext_data_write_o <= wr_ok && mgmt_req_i.addr == `PCM_ADDR_EXT_DATA;
    end
  end

  assign phy_ctrl_o.soft_reset = (state == pcm_pkg::PCM_SOFT_RESET);
  assign phy_ctrl_o.pcs_local_loop = pcs_local_loop;
  assign phy_ctrl_o.soft_powerdown = soft_powerdown;
  assign phy_ctrl_o.mii_detach = mii_detach;
  assign phy_ctrl_o.autoneg_on = ~forced_link_mode_enable_i;
  assign ext_access_function_select_o =
    ext_reg_access_control[`PCM_EXT_FUNC_HI:`PCM_EXT_FUNC_LO];
  assign ext_data_o = ext_reg_access_data;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic ctl_write;
  logic ctl_read;
  assign ctl_write = wr_ok && mgmt_req_i.addr == `PCM_ADDR_CONTROL;
  assign ctl_read = rd && mgmt_req_i.addr == `PCM_ADDR_CONTROL;
  // counts consecutive soft reset cycles, so the length needs no long repetition
  int unsigned soft_len;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_len <= '0;
    end else begin
      soft_len <= phy_ctrl_o.soft_reset ? soft_len + 32'd1 : '0;
    end
  end

  sequence s_soft_start;
    ctl_write && mgmt_req_i.wdata[`PCM_CTL_SOFT_RESET];
  endsequence
  sequence s_soft_enter;
    phy_ctrl_o.soft_reset && soft_len == 0;
  endsequence
  sequence s_soft_leave;
    !phy_ctrl_o.soft_reset && soft_len == SOFT_RESET_CYCLES;
  endsequence

  property p_soft_reset_cycle;
    s_soft_start |=> s_soft_enter;
  endproperty
  a_soft_reset_cycle: assert property (p_soft_reset_cycle)
    else $error("soft reset cycle did not start");
  property p_soft_reset_length;
    $fell(phy_ctrl_o.soft_reset) |-> s_soft_leave;
  endproperty
  a_soft_reset_length: assert property (p_soft_reset_length)
    else $error("soft reset cycle length wrong");

  property p_loop_follows_write;
    ctl_write && !mgmt_req_i.wdata[`PCM_CTL_SOFT_RESET]
      |=> phy_ctrl_o.pcs_local_loop == $past(mgmt_req_i.wdata[`PCM_CTL_PCS_LOOP]);
  endproperty
  a_loop_follows_write: assert property (p_loop_follows_write)
    else $error("loopback does not follow control write");

  property p_autoneg_readback;
    ctl_read |=> mgmt_rdata_o[`PCM_CTL_AUTONEG] == !$past(forced_link_mode_enable_i);
  endproperty
  a_autoneg_readback: assert property (p_autoneg_readback)
    else $error("autoneg bit readback wrong");

  property p_powerdown_write;
    ctl_write && !strap_pending
      |=> phy_ctrl_o.soft_powerdown == $past(mgmt_req_i.wdata[`PCM_CTL_POWERDOWN]);
  endproperty
  a_powerdown_write: assert property (p_powerdown_write)
    else $error("power-down does not follow control write");

  property p_strap_load;
    strap_pending |=> soft_powerdown == $past(powerdown_strap_pin_i);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("power-down not loaded from strap");

  property p_detach_write;
    ctl_write |=> phy_ctrl_o.mii_detach == $past(mgmt_req_i.wdata[`PCM_CTL_MII_DETACH]);
  endproperty
  a_detach_write: assert property (p_detach_write)
    else $error("mii detach does not follow control write");

  property p_fixed_ctrl_bits;
    ctl_read |=> mgmt_rdata_o[8:5] == 4'h8 && !mgmt_rdata_o[`PCM_CTL_SPEED_LOW];
  endproperty
  a_fixed_ctrl_bits: assert property (p_fixed_ctrl_bits)
    else $error("fixed control bits read wrong");

  property p_link_latch_low;
    !link_up_i ##1 (link_up_i && !(rd && mgmt_req_i.addr == `PCM_ADDR_STATUS))
      |=> !latched_link_state;
  endproperty
  a_link_latch_low: assert property (p_link_latch_low)
    else $error("link status did not latch low");

  property p_unmapped_read;
    rd && mgmt_req_i.addr > `PCM_ADDR_EXT_DATA |=> mgmt_rvalid_o && mgmt_rdata_o == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

endmodule

// file: tb/pcm_station.sv
// management station model: one access at a time, bus scrambled when idle
module pcm_station (
  // clock
  input wire logic clock_i,
  // management access
  output pcm_pkg::pcm_mgmt_req_t req_o,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  task automatic release_bus();
    req_o <= '{1'b0, ~req_o.write, ~req_o.addr, ~req_o.wdata};
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    req_o <= '{1'b1, 1'b1, a, d};
    @(posedge clock_i);
    release_bus();
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock_i);
    req_o <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge clock_i);
    release_bus();
    #1;
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
  endtask
endmodule

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic strap = 1'b0;
  logic link = 1'b1;
  logic anc = 1'b0;
  logic forced = 1'b0;
  pcm_pkg::pcm_mgmt_req_t req;
  pcm_pkg::pcm_phy_ctrl_t ctrl;
  logic [15:0] rdata;
  logic [15:0] ext_data;
  logic [15:0] v;
  logic [1:0] fsel;
  logic rvalid;
  logic ext_wr;
  int err_count = 0;
  int num_checks = 0;
  int sr_cycles = 0;
  int wr_pulses = 0;
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (ctrl.soft_reset === 1'b1) sr_cycles++;
    if (ext_wr === 1'b1) wr_pulses++;
  end
  pcm_regs DUT (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .mgmt_req_i(req),
    .mgmt_rdata_o(rdata),
    .mgmt_rvalid_o(rvalid),
    .powerdown_strap_pin_i(strap),
    .link_up_i(link),
    .an_complete_i(anc),
    .forced_link_mode_enable_i(forced),
    .phy_ctrl_o(ctrl),
    .ext_access_function_select_o(fsel),
    .ext_data_o(ext_data),
    .ext_data_write_o(ext_wr)
  );
  pcm_station ST (
    .clock_i(clock_i),
    .req_o(req),
    .rdata_i(rdata),
    .rvalid_i(rvalid)
  );
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    ST.rd(a, v);
    chk($sformatf("read %h", a), v, exp);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #60000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rdc(5'h00, 16'h1100);
    rdc(5'h01, 16'h1009);
    rdc(5'h02, 16'h1234);
    rdc(5'h03, 16'h5671);
    rdc(5'h0d, 16'h0000);
    rdc(5'h0e, 16'h0000);
    rdc(5'h05, 16'h0000);
    rdc(5'h1f, 16'h0000);
    $display("test reset values done");
    rdc(5'h01, 16'h100d);
    @(posedge clock_i) link <= 1'b0;
    @(posedge clock_i) link <= 1'b1;
    rdc(5'h01, 16'h1009);
    @(posedge clock_i) anc <= 1'b1;
    rdc(5'h01, 16'h102d);
    $display("test link latch done");
    ST.wr(5'h00, 16'h7fff);
    rdc(5'h00, 16'h5d00);
    chk("ctrl", {11'h000, ctrl}, 16'h000f);
    @(posedge clock_i) forced <= 1'b1;
    rdc(5'h00, 16'h4d00);
    chk("ctrl", {11'h000, ctrl}, 16'h000e);
    ST.wr(5'h01, 16'hffff);
    ST.wr(5'h02, 16'h0000);
    ST.wr(5'h1f, 16'h0000);
    rdc(5'h00, 16'h4d00);
    rdc(5'h02, 16'h1234);
    ST.wr(5'h00, 16'h0000);
    rdc(5'h00, 16'h0100);
    $display("test control done");
    for (int f = 0; f < 4; f++) begin
      ST.wr(5'h0d, {f[1:0], 14'h00a5});
      chk("fsel", {14'h0000, fsel}, f[15:0]);
      rdc(5'h0d, {f[1:0], 14'h00a5});
    end
    ST.wr(5'h0e, 16'h1357);
    rdc(5'h0e, 16'h1357);
    chk("ext data", ext_data, 16'h1357);
    chk("ext strobes", wr_pulses[15:0], 16'h0001);
    $display("test extended access done");
    @(posedge clock_i) begin
      strap <= 1'b1;
      forced <= 1'b0;
    end
    ST.wr(5'h00, 16'h8000);
    rdc(5'h00, 16'h9100);
    for (int i = 0; i < 40 && ctrl.soft_reset !== 1'b0; i++) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
    chk("reset cycles", sr_cycles[15:0], 16'h0010);
    rdc(5'h00, 16'h1900);
    rdc(5'h0d, 16'h0000);
    $display("test soft reset done");
    summarize();
  end
endmodule
